// ### hw/tes_pkg.sv
// tes_pkg: constants, types and helpers for the touch event/status block.
// assumes one 25 MHz clock domain; register access is over the I2C pins.
//
// Overview of operation
// R1 - eight-bit event source: reset, touch, release, near, far, comp, conv
// R2 - event source bit 0 always reads back as zero
// R3 - event flags stick until the event source register is next read
// R4 - event line asserts for any flagged event not masked at 0x09
// R5 - masking only hides the event from the line, flag still recorded
// R6 - writing one to event source bit 2 starts compensation on all channels
// R7 - eight-bit read-only touch state, bit n for channel n, one is touch
// R8 - touch needs difference above threshold plus margin for debounce cycles
// R9 - release needs difference below threshold minus margin for debounce
// R10 - touch state is live only, never saved to or loaded from storage
// R11 - debounce register: touch count in bits 3:2, release count in 1:0
// R12 - margin from negative filter bits 7:5, code one gives eight counts
// R13 - software reset register sits at address 0xFF
// R14 - event line low on unmasked event, high after event source is read
// R15 - the pin works as the event line only when its function field is 00
// R16 - debounce count restarts whenever a cycle fails its condition
package tes_pkg;

  localparam int NCH = 8;

  // register addresses
  localparam logic [7:0] A_EVENT_SOURCE = 8'h00;
  localparam logic [7:0] A_TOUCH_STATE  = 8'h01;
  localparam logic [7:0] A_PIN_TWO_CFG  = 8'h07;
  localparam logic [7:0] A_EVENT_MASK   = 8'h09;
  localparam logic [7:0] A_THRESH_BASE  = 8'h28;
  localparam logic [7:0] A_DEBOUNCE     = 8'h33;
  localparam logic [7:0] A_NEG_FILT     = 8'h37;
  localparam logic [7:0] A_SOFT_RESET   = 8'hFF;

  // event source bit positions
  localparam int EV_RESET   = 7;
  localparam int EV_TOUCH   = 6;
  localparam int EV_RELEASE = 5;
  localparam int EV_NEAR    = 4;
  localparam int EV_FAR     = 3;
  localparam int EV_COMP    = 2;
  localparam int EV_CONV    = 1;

  // reset values and writable-bit masks
  localparam logic [7:0] EV_IMPL_MASK     = 8'hFE;
  localparam logic [7:0] EVENT_SOURCE_RST = 8'h80;
  localparam logic [7:0] EVENT_MASK_RST   = 8'h00;
  localparam logic [7:0] PIN_TWO_CFG_RST  = 8'h00;
  localparam logic [7:0] PIN_TWO_CFG_MASK = 8'h70;
  localparam logic [7:0] DEBOUNCE_RST     = 8'h00;
  localparam logic [7:0] DEBOUNCE_MASK    = 8'h0F;
  localparam logic [7:0] NEG_FILT_RST     = 8'h00;
  localparam logic [7:0] THRESH_RST       = 8'h00;

  // field positions and scaling
  localparam int         PIN_FN_LSB        = 5;
  localparam logic [1:0] PIN_FN_EVENT_LINE = 2'b00;
  localparam int         TDEB_LSB          = 2;
  localparam int         RDEB_LSB          = 0;
  localparam int         HYST_LSB          = 5;
  localparam int         THRESH_SHIFT      = 4;
  localparam int         HYST_SHIFT        = 3;

  // value that triggers a soft reset when written to A_SOFT_RESET
  localparam logic [7:0] SOFT_RESET_KEY = 8'hDE;
  // bus address, arbitrary value
  localparam logic [6:0] I2C_ADDR_DFLT  = 7'h2B;

  // one-cycle pulses from the measurement front end
  typedef struct packed {
    logic prox_near;
    logic prox_far;
    logic comp_done;
    logic meas_done;
  } tes_evt_s;

  // settings shared by all channels
  typedef struct packed {
    logic [2:0] hyst_code;
    logic [1:0] touch_deb;
    logic [1:0] rel_deb;
  } tes_chan_cfg_s;

  typedef logic [NCH-1:0][15:0] tes_diff_t;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_PTR, I2C_DACK,
    I2C_WDATA, I2C_RDATA, I2C_RACK
  } tes_i2c_e;

  // address falls in the per-channel threshold window
  function automatic logic tes_is_thresh(input logic [7:0] a);
    return (a >= A_THRESH_BASE) && (a < A_THRESH_BASE + 8'(NCH));
  endfunction

endpackage

// ### hw/tes_touch_chan.sv
// tes_touch_chan: touch/release qualifier for one sense channel.
// assumes meas_done is a one-cycle pulse per measurement cycle, same clock.
`timescale 1ns/1ps
module tes_touch_chan
  import tes_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clear,
  // measurement
  input  wire logic          meas_done,
  input  wire logic [15:0]   diff,
  input  wire logic [7:0]    thresh_code,
  input  wire tes_chan_cfg_s cfg,
  // state and events
  output logic               touched_r,
  output logic               touch_ev_r,
  output logic               release_ev_r
);

  logic        touched_nxt;
  logic        touch_ev_nxt;
  logic        release_ev_nxt;
  logic [1:0]  cnt_r;
  logic [1:0]  cnt_nxt;
  logic [17:0] diff_x;
  logic [17:0] upper;
  logic [17:0] lower;
  logic        above;
  logic        below;

  // signed compare in 18 bits so thresh minus margin may go negative
  assign diff_x = {{2{diff[15]}}, diff};
  assign upper  = 18'({thresh_code, 4'h0}) + 18'({cfg.hyst_code, 3'h0});
  assign lower  = 18'({thresh_code, 4'h0}) - 18'({cfg.hyst_code, 3'h0});
  assign above  = $signed(diff_x) > $signed(upper);  // [R8] [R12]
  assign below  = $signed(diff_x) < $signed(lower);  // [R9] [R12]

  // debounce: count qualifying cycles, code n means n+1 cycles
  always_comb begin
    touched_nxt    = touched_r;
    cnt_nxt        = cnt_r;
    touch_ev_nxt   = 1'b0;
    release_ev_nxt = 1'b0;
    if (clear) begin
      touched_nxt = 1'b0;
      cnt_nxt     = 2'h0;
    end else if (meas_done) begin
      if (!touched_r) begin
        if (!above) begin
          cnt_nxt = 2'h0;                       // [R16]
        end else if (cnt_r == cfg.touch_deb) begin
          touched_nxt  = 1'b1;                  // [R8] [R11]
          touch_ev_nxt = 1'b1;
          cnt_nxt      = 2'h0;
        end else begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end else begin
        if (!below) begin
          cnt_nxt = 2'h0;                       // [R16]
        end else if (cnt_r == cfg.rel_deb) begin
          touched_nxt    = 1'b0;                // [R9] [R11]
          release_ev_nxt = 1'b1;
          cnt_nxt        = 2'h0;
        end else begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
    end
  end

  // live state only, cleared by reset, never reloaded [R10]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touched_r    <= 1'b0;
      cnt_r        <= 2'h0;
      touch_ev_r   <= 1'b0;
      release_ev_r <= 1'b0;
    end else begin
      touched_r    <= touched_nxt;
      cnt_r        <= cnt_nxt;
      touch_ev_r   <= touch_ev_nxt;
      release_ev_r <= release_ev_nxt;
    end
  end

endmodule

// ### hw/tes_top.sv
// tes_top: event flags, touch state and I2C register slave.
// assumes scl/sda come from pins (synchronised here), front-end pulses
// and difference values are on ref_clk; the open-drain wires are resolved
// outside from the output enables.
`timescale 1ns/1ps
module tes_top
  import tes_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = I2C_ADDR_DFLT
)(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      resetn,
  // i2c pins
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  // multi-function pin two as event line
  output logic           event_line_n_o,
  output logic           event_line_n_oe,
  // measurement front end
  input  wire tes_evt_s  fe_evt,
  input  wire tes_diff_t baseline_difference,
  output logic           comp_start
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_meta_r;
  logic rst_n;
  logic scl_meta_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_meta_r;
  logic sda_s_r;
  logic sda_d_r;

  // reset asserts at once, releases after two edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // third stage only feeds edge detection, never the meta flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_r <= 1'b1;
      scl_s_r    <= 1'b1;
      scl_d_r    <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      scl_s_r    <= scl_meta_r;
      scl_d_r    <= scl_s_r;
      sda_meta_r <= sda_i;
      sda_s_r    <= sda_meta_r;
      sda_d_r    <= sda_s_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  ////////////////////////////////////////////////////////////////////////
  // per-channel touch qualifiers

  logic [NCH-1:0]      touch_st;
  logic [NCH-1:0]      touch_ev;
  logic [NCH-1:0]      rel_ev;
  logic [NCH-1:0][7:0] thresh_r;
  logic [7:0]          deb_r;
  logic [7:0]          negf_r;
  logic                soft_rst_r;
  tes_chan_cfg_s       chan_cfg;

  assign chan_cfg.hyst_code = negf_r[HYST_LSB+:3];   // [R12]
  assign chan_cfg.touch_deb = deb_r[TDEB_LSB+:2];    // [R11]
  assign chan_cfg.rel_deb   = deb_r[RDEB_LSB+:2];    // [R11]

  // bit n of touch state is channel n [R7]
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    tes_touch_chan u_chan (
      .clk          (ref_clk),
      .rst_n        (rst_n),
      .clear        (soft_rst_r),
      .meas_done    (fe_evt.meas_done),
      .diff         (baseline_difference[g]),
      .thresh_code  (thresh_r[g]),
      .cfg          (chan_cfg),
      .touched_r    (touch_st[g]),
      .touch_ev_r   (touch_ev[g]),
      .release_ev_r (rel_ev[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // register slave, event flags and configuration

  tes_i2c_e            state_r;
  tes_i2c_e            state_nxt;
  logic [3:0]          bitcnt_r;
  logic [3:0]          bitcnt_nxt;
  logic [7:0]          shift_r;
  logic [7:0]          shift_nxt;
  logic [7:0]          tx_r;
  logic [7:0]          tx_nxt;
  logic [7:0]          ptr_r;
  logic [7:0]          ptr_nxt;
  logic                rw_r;
  logic                rw_nxt;
  logic                sda_oe_nxt;
  logic [7:0]          evsrc_r;
  logic [7:0]          evsrc_nxt;
  logic [7:0]          mask_r;
  logic [7:0]          mask_nxt;
  logic [7:0]          pincfg_r;
  logic [7:0]          pincfg_nxt;
  logic [7:0]          deb_nxt;
  logic [7:0]          negf_nxt;
  logic [NCH-1:0][7:0] thresh_nxt;
  logic                soft_rst_nxt;
  logic                comp_start_nxt;
  logic                evl_oe_nxt;
  logic                wr;
  logic                load;
  logic [7:0]          rd_data;
  logic [7:0]          ev_set;
  logic [7:0]          ev_clr;

  // read mux; unmapped and reserved addresses read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == A_EVENT_SOURCE) begin
      r = evsrc_r & EV_IMPL_MASK;                    // [R2]
    end else if (a == A_TOUCH_STATE) begin
      r = touch_st;                                  // [R7]
    end else if (a == A_PIN_TWO_CFG) begin
      r = pincfg_r;
    end else if (a == A_EVENT_MASK) begin
      r = mask_r;
    end else if (a == A_DEBOUNCE) begin
      r = deb_r;
    end else if (a == A_NEG_FILT) begin
      r = negf_r;
    end else if (tes_is_thresh(a)) begin
      r = thresh_r[3'(a - A_THRESH_BASE)];
    end
    return r;
  endfunction

  always_comb rd_data = rd_byte(ptr_r);  // sees flag changes, not just ptr

  // byte engine: shift on scl rise, drive on scl fall
  always_comb begin
    state_nxt  = state_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt  = shift_r;
    tx_nxt     = tx_r;
    ptr_nxt    = ptr_r;
    rw_nxt     = rw_r;
    sda_oe_nxt = sda_oe;
    wr         = 1'b0;
    load       = 1'b0;
    if (start_ev) begin
      state_nxt  = I2C_ADDR;
      bitcnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt  = I2C_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          shift_nxt  = {shift_r[6:0], sda_s_r};
          bitcnt_nxt = bitcnt_r + 4'h1;
        end
        I2C_RACK: begin
          if (sda_s_r) begin
            state_nxt = I2C_IDLE;                    // master nack ends read
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_r)
        I2C_ADDR: begin
          if (bitcnt_r == 4'h8) begin
            if (shift_r[7:1] == DEV_ADDR) begin
              rw_nxt     = shift_r[0];
              sda_oe_nxt = 1'b1;
              state_nxt  = I2C_AACK;
            end else begin
              state_nxt = I2C_IDLE;
            end
          end
        end
        I2C_PTR: begin
          if (bitcnt_r == 4'h8) begin
            ptr_nxt    = shift_r;
            sda_oe_nxt = 1'b1;
            state_nxt  = I2C_DACK;
          end
        end
        I2C_WDATA: begin
          if (bitcnt_r == 4'h8) begin
            wr         = 1'b1;
            ptr_nxt    = ptr_r + 8'h01;
            sda_oe_nxt = 1'b1;
            state_nxt  = I2C_DACK;
          end
        end
        I2C_AACK: begin
          bitcnt_nxt = 4'h0;
          if (rw_r) begin
            load      = 1'b1;
            state_nxt = I2C_RDATA;
          end else begin
            sda_oe_nxt = 1'b0;
            state_nxt  = I2C_PTR;
          end
        end
        I2C_DACK: begin
          bitcnt_nxt = 4'h0;
          sda_oe_nxt = 1'b0;
          state_nxt  = I2C_WDATA;
        end
        I2C_RDATA: begin
          if (bitcnt_r == 4'h8) begin
            sda_oe_nxt = 1'b0;
            state_nxt  = I2C_RACK;
          end else begin
            sda_oe_nxt = ~tx_r[7];
            tx_nxt     = {tx_r[6:0], 1'b0};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
        end
        I2C_RACK: begin
          load      = 1'b1;
          state_nxt = I2C_RDATA;
        end
        default: begin
        end
      endcase
    end
    // a load presents bit 7 now and walks the pointer on
    if (load) begin
      sda_oe_nxt = ~rd_data[7];
      tx_nxt     = {rd_data[6:0], 1'b0};
      bitcnt_nxt = 4'h1;
      ptr_nxt    = ptr_r + 8'h01;
    end
  end

  // event flags: a set landing with the read-clear still wins [R1] [R3]
  always_comb begin
    ev_set          = 8'h00;
    ev_set[EV_TOUCH]   = |touch_ev;
    ev_set[EV_RELEASE] = |rel_ev;
    ev_set[EV_NEAR]    = fe_evt.prox_near;
    ev_set[EV_FAR]     = fe_evt.prox_far;
    ev_set[EV_COMP]    = fe_evt.comp_done;
    ev_set[EV_CONV]    = fe_evt.meas_done;
    // only the bits actually shifted out are cleared, so none is lost
    ev_clr = (load && ptr_r == A_EVENT_SOURCE) ? rd_data : 8'h00;  // [R3]
    if (soft_rst_r) begin
      evsrc_nxt = EVENT_SOURCE_RST | ev_set;
    end else begin
      evsrc_nxt = ((evsrc_r & ~ev_clr) | ev_set) & EV_IMPL_MASK;   // [R2]
    end
  end

  // register writes and their side effects
  always_comb begin
    mask_nxt       = mask_r;
    pincfg_nxt     = pincfg_r;
    deb_nxt        = deb_r;
    negf_nxt       = negf_r;
    thresh_nxt     = thresh_r;
    soft_rst_nxt   = 1'b0;
    comp_start_nxt = 1'b0;
    if (soft_rst_r) begin
      mask_nxt   = EVENT_MASK_RST;
      pincfg_nxt = PIN_TWO_CFG_RST;
      deb_nxt    = DEBOUNCE_RST;
      negf_nxt   = NEG_FILT_RST;
      thresh_nxt = {NCH{THRESH_RST}};
    end else if (wr) begin
      if (ptr_r == A_EVENT_SOURCE) begin
        comp_start_nxt = shift_r[EV_COMP];           // [R6]
      end else if (ptr_r == A_PIN_TWO_CFG) begin
        pincfg_nxt = shift_r & PIN_TWO_CFG_MASK;
      end else if (ptr_r == A_EVENT_MASK) begin
        mask_nxt = shift_r;
      end else if (ptr_r == A_DEBOUNCE) begin
        deb_nxt = shift_r & DEBOUNCE_MASK;           // [R11]
      end else if (ptr_r == A_NEG_FILT) begin
        negf_nxt = shift_r;                          // [R12]
      end else if (tes_is_thresh(ptr_r)) begin
        thresh_nxt[3'(ptr_r - A_THRESH_BASE)] = shift_r;
      end else if (ptr_r == A_SOFT_RESET) begin
        soft_rst_nxt = (shift_r == SOFT_RESET_KEY);  // [R13]
      end
    end
  end

  // line pulled low while an unmasked flag stands, in event mode only
  always_comb begin
    evl_oe_nxt = (pincfg_r[PIN_FN_LSB+:2] == PIN_FN_EVENT_LINE) &&  // [R15]
                 (|(evsrc_r & ~mask_r));             // [R4] [R5] [R14]
  end

  // all registered state of the slave
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r         <= I2C_IDLE;
      bitcnt_r        <= 4'h0;
      shift_r         <= 8'h00;
      tx_r            <= 8'h00;
      ptr_r           <= 8'h00;
      rw_r            <= 1'b0;
      sda_oe          <= 1'b0;
      sda_o           <= 1'b0;
      evsrc_r         <= EVENT_SOURCE_RST;
      mask_r          <= EVENT_MASK_RST;
      pincfg_r        <= PIN_TWO_CFG_RST;
      deb_r           <= DEBOUNCE_RST;
      negf_r          <= NEG_FILT_RST;
      thresh_r        <= {NCH{THRESH_RST}};
      soft_rst_r      <= 1'b0;
      comp_start      <= 1'b0;
      event_line_n_o  <= 1'b0;
      event_line_n_oe <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      bitcnt_r        <= bitcnt_nxt;
      shift_r         <= shift_nxt;
      tx_r            <= tx_nxt;
      ptr_r           <= ptr_nxt;
      rw_r            <= rw_nxt;
      sda_oe          <= sda_oe_nxt;
      sda_o           <= 1'b0;                       // open drain: low only
      evsrc_r         <= evsrc_nxt;
      mask_r          <= mask_nxt;
      pincfg_r        <= pincfg_nxt;
      deb_r           <= deb_nxt;
      negf_r          <= negf_nxt;
      thresh_r        <= thresh_nxt;
      soft_rst_r      <= soft_rst_nxt;
      comp_start      <= comp_start_nxt;
      event_line_n_o  <= 1'b0;
      event_line_n_oe <= evl_oe_nxt;
    end
  end

endmodule

// ### tb/tes_top_assertions.sv
// tes_top_assertions: port-level checks on the touch event block.
// assumes one ref_clk domain, resetn as its reset, scl low phase >11 clocks.
`timescale 1ns/1ps
module tes_checker
  import tes_pkg::*;
(
  // clock and reset
  input wire logic      ref_clk,
  input wire logic      resetn,
  // bus and pins
  input wire logic      scl_i,
  input wire logic      sda_i,
  input wire logic      sda_o,
  input wire logic      sda_oe,
  input wire logic      event_line_n_o,
  input wire logic      event_line_n_oe,
  // front end
  input wire tes_evt_s  fe_evt,
  input wire tes_diff_t baseline_difference,
  input wire logic      comp_start
);
  logic [7:0] scl_age_r;
  logic [7:0] scl_age_nxt;
  logic [7:0] evt_age_r;
  logic [7:0] evt_age_nxt;
  logic [7:0] rst_age_r;
  logic [7:0] rst_age_nxt;
  logic       scl_q_r;

  function automatic logic [7:0] inc(input logic [7:0] x);
    return (x == 8'hFF) ? x : x + 8'h01;
  endfunction

  // ages since last scl fall, front-end pulse and reset release
  always_comb begin
    scl_age_nxt = (scl_q_r && !scl_i) ? 8'h00 : inc(scl_age_r);
    evt_age_nxt = (|fe_evt) ? 8'h00 : inc(evt_age_r);
    rst_age_nxt = inc(rst_age_r);
  end

  // saturating, so a quiet bus never wraps back into a window
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_age_r <= 8'hFF;
      evt_age_r <= 8'hFF;
      rst_age_r <= 8'h00;
      scl_q_r   <= 1'b1;
    end else begin
      scl_age_r <= scl_age_nxt;
      evt_age_r <= evt_age_nxt;
      rst_age_r <= rst_age_nxt;
      scl_q_r   <= scl_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_comp_pulse;
    comp_start ##1 !comp_start;
  endsequence
  sequence s_bus_window;
    (scl_age_r <= 8'h0B) && !scl_i;
  endsequence

  a_line_od_low: assert property (event_line_n_o == 1'b0)
    else $error("event line data not low");
  a_sda_od_low: assert property (sda_o == 1'b0)
    else $error("sda data not low");
  a_comp_one_cycle: assert property ($rose(comp_start) |-> s_comp_pulse)
    else $error("compensation start wider than one cycle");
  a_comp_after_write: assert property (comp_start |-> s_bus_window)
    else $error("compensation start without a bus write");
  a_line_rise_cause: assert property ($rose(event_line_n_oe) |->
    (evt_age_r <= 8'h06) or s_bus_window or (rst_age_r <= 8'h08))
    else $error("event line asserted without a cause");
  a_line_fall_read: assert property ($fell(event_line_n_oe) |-> s_bus_window)
    else $error("event line released outside a bus access");
  a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_sda_after_fall: assert property ($rose(sda_oe) |-> ##1 sda_oe[*4])
    else $error("sda drive shorter than five cycles");
endmodule

bind tes_top tes_checker u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .event_line_n_o(event_line_n_o),
  .event_line_n_oe(event_line_n_oe), .fe_evt(fe_evt),
  .baseline_difference(baseline_difference), .comp_start(comp_start)
);

// ### tb/tes_host_model.sv
// tes_host_model: host processor reaching the registers as a bus master.
// assumes sda_i is the resolved wire with a pull-up; moves on falling edges.
`timescale 1ns/1ps
module tes_host_model
  import tes_pkg::*;
(
  // clock
  input  wire logic ref_clk,
  // bus wires
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull
);
  localparam int Q = 6;  // quarter scl period, slow enough for the sync
  int unsigned nacks;

  initial begin
    scl_o    = 1'b1;
    sda_pull = 1'b0;
    nacks    = 0;
  end

  task automatic wt();
    repeat (Q) @(negedge ref_clk);
  endtask

  // data moves only mid-low, sampled mid-high
  task automatic xfer(input logic b, output logic s);
    wt();
    sda_pull = !b;
    wt();
    scl_o = 1'b1;
    wt();
    s = sda_i;
    wt();
    scl_o = 1'b0;
  endtask

  task automatic start();
    wt();
    sda_pull = 1'b0;
    wt();
    scl_o = 1'b1;
    wt();
    sda_pull = 1'b1;
    wt();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    wt();
    sda_pull = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    sda_pull = 1'b0;
    wt();
  endtask

  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(d[i], s);
    xfer(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    start();
    wbyte({I2C_ADDR_DFLT, 1'b0});
    wbyte(a);
    wbyte(d);
    stop();
  endtask

  // single-byte read, ended by a not-acknowledge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    logic s;
    start();
    wbyte({I2C_ADDR_DFLT, 1'b0});
    wbyte(a);
    start();
    wbyte({I2C_ADDR_DFLT, 1'b1});
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(1'b1, s);
    stop();
  endtask
endmodule

// ### tb/tb_touch_event_status.sv
// tb_touch_event_status: self-checking bench for the touch event block.
// assumes tes_host_model as bus master; front end driven on falling edges.
`timescale 1ns/1ps
module tb_touch_event_status;
  import tes_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn, scl, sda, pull, sda_oe, line_oe, comp_start, event_line_n;
  tes_evt_s   fe_evt;
  tes_diff_t  diff;
  int         num_errors = 0, compares = 0, comp_n = 0;
  int unsigned seed_v;
  logic [7:0] exp_q[$], seen;
  string      nam_q[$];
  event       seen_ev;

  always #20 ref_clk = ~ref_clk;
  // open-drain wires with pull-ups
  assign sda = !(sda_oe || pull);
  assign event_line_n = !line_oe;

  tes_top dut (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe(sda_oe), .event_line_n_o(), .event_line_n_oe(line_oe),
    .fe_evt(fe_evt), .baseline_difference(diff), .comp_start(comp_start));
  tes_host_model host (.ref_clk(ref_clk), .sda_i(sda), .scl_o(scl),
    .sda_pull(pull));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // note the expectation, then let the monitor compare on arrival
  task automatic rd(string n, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    exp_q.push_back(e);
    nam_q.push_back(n);
    host.reg_rd(a, d);
    seen = d;
    -> seen_ev;
    #1;
  endtask

  initial forever begin
    @(seen_ev);
    chk(nam_q.pop_front(), seen, exp_q.pop_front());
  end

  always @(posedge ref_clk) if (comp_start === 1'b1) comp_n++;

  task automatic line(string n, logic e);
    chk(n, {7'h00, event_line_n}, {7'h00, e});
  endtask

  task automatic pulse(logic [3:0] e);
    @(negedge ref_clk);
    fe_evt = tes_evt_s'(e);
    @(negedge ref_clk);
    fe_evt = '0;
    repeat (4) @(negedge ref_clk);
  endtask

  // channel 2 gets v, the rest stay inside the margin around zero
  task automatic meas(logic [15:0] v);
    for (int g = 0; g < NCH; g++) diff[g] = 16'($urandom_range(16)) - 16'h0008;
    diff[2] = v;
    pulse(4'h1);
  endtask

  function automatic logic [15:0] above();
    return 16'h0199 + 16'($urandom_range(40));  // 409 and up
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    fe_evt = '0;
    diff   = '0;
    seed_v = $urandom(31757);
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (8) @(negedge ref_clk);
    line("line at reset", 1'b0);
    rd("src reset", A_EVENT_SOURCE, 8'h80);
    rd("src cleared", A_EVENT_SOURCE, 8'h00);
    line("line after read", 1'b1);
    $display("test reset done");
    // each front-end event, first masked then unmasked
    for (int i = 0; i < 4; i++) begin
      host.reg_wr(A_EVENT_MASK, 8'h02 << i);
      pulse(4'h1 << i);
      line("line masked", 1'b1);
      host.reg_wr(A_EVENT_MASK, 8'h00);
      line("line unmasked", 1'b0);
      rd("src event", A_EVENT_SOURCE, 8'h02 << i);
      line("line released", 1'b1);
    end
    pulse(4'h8);
    pulse(4'h4);
    rd("src sticky", A_EVENT_SOURCE, 8'h18);
    $display("test events done");
    for (int c = 1; c < 4; c++) begin
      host.reg_wr(A_PIN_TWO_CFG, 8'(c << PIN_FN_LSB));
      pulse(4'h8);
      line("line other function", 1'b1);
    end
    host.reg_wr(A_PIN_TWO_CFG, 8'h00);
    line("line event function", 1'b0);
    rd("src pin two", A_EVENT_SOURCE, 8'h10);
    $display("test pin function done");
    pulse(4'h4);
    host.reg_wr(A_EVENT_SOURCE, 8'hFB);
    chk("comp none", 8'(comp_n), 8'h00);
    host.reg_wr(A_EVENT_SOURCE, 8'h04);
    chk("comp once", 8'(comp_n), 8'h01);
    rd("src after comp", A_EVENT_SOURCE, 8'h08);
    $display("test compensation done");
    // threshold 400, margin 8: touch above 408, release below 392
    host.reg_wr(A_THRESH_BASE + 8'h02, 8'h19);
    host.reg_wr(A_NEG_FILT, 8'h20);
    for (int c = 0; c < 4; c++) begin
      host.reg_wr(A_DEBOUNCE, 8'(c << TDEB_LSB));
      if (c > 0) meas(above());
      meas(16'h0198);
      repeat (c) meas(above());
      rd("touch pending", A_TOUCH_STATE, 8'h00);
      meas(above());
      rd("touch set", A_TOUCH_STATE, 8'h04);
      meas(16'h0187 - 16'($urandom_range(40)));
      rd("touch lost", A_TOUCH_STATE, 8'h00);
    end
    rd("src touch", A_EVENT_SOURCE, 8'h62);
    host.reg_wr(A_DEBOUNCE, 8'h01);
    meas(above());
    meas(16'h0187);
    meas(16'h0190);
    meas(16'h0187);
    rd("release restart", A_TOUCH_STATE, 8'h04);
    meas(16'h0187);
    rd("release two", A_TOUCH_STATE, 8'h00);
    $display("test touch done");
    meas(above());
    host.reg_wr(A_EVENT_MASK, 8'hFF);
    host.reg_wr(A_SOFT_RESET, SOFT_RESET_KEY);
    rd("touch soft reset", A_TOUCH_STATE, 8'h00);
    rd("mask soft reset", A_EVENT_MASK, EVENT_MASK_RST);
    rd("src soft reset", A_EVENT_SOURCE, 8'h80);
    rd("unmapped", 8'h05, 8'h00);
    chk("nacks", 8'(host.nacks), 8'h00);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
